// *** mmc_cfg.svh ***
// constants for the memory map and clock/reset controller
`ifndef MMC_CFG_SVH
`define MMC_CFG_SVH
`define MMC_CLK_MHZ        125
`define MMC_RC_SETTLE_NS   100000
`define MMC_XTAL_SETTLE_NS 2750000
`define MMC_ROM_WORDS      49152
`define MMC_RAM_WORDS      24576
`define MMC_FUSE_WORDS     12
`define MMC_FUSE_KEY_LO    8
`define MMC_PERI_LAT       3
`define MMC_ROM_BASE       32'h0000_0000
`define MMC_ROM_BYTES      32'h0003_0000
`define MMC_FUSE_BASE      32'h0100_0000
`define MMC_FUSE_BYTES     32'h0000_0030
`define MMC_PERI_BASE      32'h0200_0000
`define MMC_PERI_BYTES     32'h0001_0000
`define MMC_RAM_BASE       32'h0400_0000
`define MMC_RAM_BYTES      32'h0001_8000
`define MMC_VEC_RESET      32'h0000_0100
`define MMC_VEC_BUS_ERR    32'h0000_0200
`endif

// *** mmc_pkg.sv ***
// types for the memory map and clock/reset controller
package mmc_pkg;
   typedef enum logic [3:0] {
      MMC_RC_WAIT   = 4'b0001,
      MMC_XTAL_WAIT = 4'b0010,
      MMC_BOOT      = 4'b0100,
      MMC_RUN       = 4'b1000
   } mmc_state_e;
   typedef struct packed {
      logic        req;
      logic        we;
      logic [3:0]  be;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mmc_cpu_req_s;
   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] rdata;
   } mmc_cpu_rsp_s;
   typedef struct packed {
      logic        sel;
      logic        we;
      logic [3:0]  be;
      logic [15:0] addr;
      logic [31:0] wdata;
   } mmc_peri_s;
endpackage : mmc_pkg

// *** mmc_ctrl.sv ***
// memory map decoder, boot copy and power-up reset sequencer
//
// What this block does
// - rom is 48k words of 32 bits, answered in one cycle
// - ram is 24k words of 32 bits for code and data, one cycle
// - ram power switch input keeps ram powered through sleep
// - fuse array of twelve words; only the last four user writable
// - the four user fuse words form the 128-bit flash key
// - flash select zero is only ever driven for the boot copy
// - after reset, flash contents are copied into ram before cpu runs
// - with encryption on, key is fetched and each word decrypted
// - peripheral register accesses take three clock cycles
// - unpopulated address is refused with a bus error
// - crystal clock runs cpu side, slow clock runs sleep; core clock runs startup
// - core clock, not slow clock, drives the sequencer while chip is in reset
// - slow source picked once by software, locked until reset
// - every chip reset returns slow source to internal rc
// - rc calibration counts fast cycles over slow periods
// - rc settles about 100 us before crystal and logic power
// - all logic held in reset until crystal settles, 2.75 ms
// - reset released to cpu and peripherals together at vector
// - any reset starts the cpu at vector 0x100
// - bus error redirects the cpu to vector 0x200
`timescale 1ns/1ps
`include "mmc_cfg.svh"
module mmc_ctrl #(
   parameter int RC_CYC   = (`MMC_RC_SETTLE_NS * `MMC_CLK_MHZ) / 1000,
   parameter int XTAL_CYC = (`MMC_XTAL_SETTLE_NS * `MMC_CLK_MHZ) / 1000,
   parameter int CAL_TICKS = 8
) (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst_b,
   input  wire logic                  sw_reset_req,
   // cpu memory bus
   input  wire mmc_pkg::mmc_cpu_req_s cpu_req,
   output logic                       cpu_ready,
   output mmc_pkg::mmc_cpu_rsp_s      cpu_rsp,
   output logic                       cpu_vec_valid,
   output logic [31:0]                cpu_vec,
   // rom macro, combinational read
   output logic [15:0]                rom_addr,
   input  wire logic [31:0]           rom_rdata,
   // peripheral register bus
   output mmc_pkg::mmc_peri_s         peri_bus,
   input  wire logic [31:0]           peri_rdata,
   // fuse programming
   input  wire logic                  fuse_prog_req,
   input  wire logic [3:0]            fuse_prog_idx,
   input  wire logic [31:0]           fuse_prog_data,
   // boot flash word stream
   input  wire logic                  boot_enc_en,
   input  wire logic [15:0]           boot_word_cnt,
   output logic                       boot_flash_select_b,
   output logic                       flash_req,
   output logic [15:0]                flash_addr,
   input  wire logic                  flash_valid,
   input  wire logic [31:0]           flash_data,
   // decrypt engine
   output logic [127:0]               dec_key,
   output logic                       dec_in_valid,
   output logic [31:0]                dec_in_data,
   input  wire logic                  dec_out_valid,
   input  wire logic [31:0]           dec_out_data,
   // power, oscillators, reset out
   input  wire logic                  ram_retain,
   output logic                       ram_pwr_en,
   output logic                       rc_osc_en,
   output logic                       xtal_en,
   output logic                       logic_pwr_en,
   output logic                       sys_rst_b,
   // slow clock
   input  wire logic                  slow_sel_strobe,
   input  wire logic                  slow_sel_ext,
   input  wire logic                  slow_rc_clock,
   input  wire logic                  slow_ref_clock_input,
   output logic                       slow_src_ext,
   output logic                       slow_clock,
   input  wire logic                  cal_start,
   output logic                       cal_done,
   output logic [31:0]                cal_count
);
   import mmc_pkg::*;

   localparam int RAM_AW = $clog2(`MMC_RAM_WORDS);

   if (RC_CYC < 1 || XTAL_CYC < 1 || RC_CYC >= 2**20 || XTAL_CYC >= 2**20)
      $error("settle counts out of range");
   if (CAL_TICKS < 1 || CAL_TICKS > 255)
      $error("CAL_TICKS out of range");

   mmc_state_e  st_ff, nxt_st;
   logic [19:0] tmr_ff;
   logic [15:0] bcnt_ff;
   logic        bwait_ff;
   logic        slow_lock_ff;
   logic        slow_src_ff;
   logic [1:0]  lat_ff;
   logic        dec_pend_ff;
   logic [31:0] fuse_mem [`MMC_FUSE_WORDS];
   logic [127:0] key_ff;

   // address decode
   wire [31:0] a       = cpu_req.addr;
   wire        hit_rom  = a < (`MMC_ROM_BASE + `MMC_ROM_BYTES);
   wire        hit_fuse = a >= `MMC_FUSE_BASE && a < (`MMC_FUSE_BASE + `MMC_FUSE_BYTES);
   wire        hit_peri = a >= `MMC_PERI_BASE && a < (`MMC_PERI_BASE + `MMC_PERI_BYTES);
   wire        hit_ram  = a >= `MMC_RAM_BASE && a < (`MMC_RAM_BASE + `MMC_RAM_BYTES);
   wire        running  = st_ff == MMC_RUN;
   wire        take     = cpu_req.req && cpu_ready;
   // rom and fuse refuse writes; only ram and peripherals take them
   wire        bad      = !(hit_ram || hit_peri || (!cpu_req.we && (hit_rom || hit_fuse)));
   wire [31:0] off_ram  = a - `MMC_RAM_BASE;
   wire [31:0] off_fuse = a - `MMC_FUSE_BASE;
   wire [RAM_AW-1:0] ram_idx = off_ram[RAM_AW+1:2];
   wire [3:0]  fuse_idx = off_fuse[5:2];

   // boot copy datapath
   wire        word_in  = bwait_ff && (boot_enc_en ? dec_out_valid : flash_valid);
   wire [31:0] word_val = boot_enc_en ? dec_out_data : flash_data;
   wire        boot_end = bcnt_ff == boot_word_cnt;
   wire [RAM_AW-1:0] boot_idx = bcnt_ff[RAM_AW-1:0];

   assign cpu_ready     = running && lat_ff == 2'd0;
   assign rom_addr      = a[17:2];
   assign boot_flash_select_b = !(st_ff == MMC_BOOT);
   // no fetch while a word sits in the decryptor, else it is fetched twice
   assign flash_req     = st_ff == MMC_BOOT && !boot_end && !dec_pend_ff;
   assign flash_addr    = bcnt_ff;
   assign dec_in_valid  = bwait_ff && boot_enc_en && flash_valid;
   assign dec_in_data   = flash_data;
   assign dec_key       = key_ff;
   // crystal side on once rc settled
   assign rc_osc_en     = 1'b1;
   assign xtal_en       = st_ff != MMC_RC_WAIT;
   assign logic_pwr_en  = st_ff != MMC_RC_WAIT;
   assign ram_pwr_en    = logic_pwr_en || ram_retain;
   // single release for cpu and peripherals
   assign sys_rst_b     = running;
   assign slow_src_ext  = slow_src_ff;
   // slow mux keeps running through reset
   assign slow_clock    = slow_src_ff ? slow_ref_clock_input : slow_rc_clock;

   // power-up sequencer
   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff)
         MMC_RC_WAIT:   if (tmr_ff == 20'(RC_CYC - 1)) nxt_st = MMC_XTAL_WAIT;
         MMC_XTAL_WAIT: if (tmr_ff == 20'(XTAL_CYC - 1)) nxt_st = MMC_BOOT;
         MMC_BOOT:      if (boot_end) nxt_st = MMC_RUN;
         MMC_RUN:       nxt_st = MMC_RUN;
      endcase
      if (sw_reset_req) nxt_st = MMC_RC_WAIT;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff  <= MMC_RC_WAIT;
         tmr_ff <= 20'h0;
      end else begin
         st_ff  <= nxt_st;
         tmr_ff <= (nxt_st != st_ff) ? 20'h0 : tmr_ff + 20'h1;
      end
   end

   // boot copy control; one word in flight at a time
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         bcnt_ff     <= 16'h0;
         bwait_ff    <= 1'b0;
         dec_pend_ff <= 1'b0;
         key_ff      <= 128'h0;
      end else if (st_ff != MMC_BOOT) begin
         bcnt_ff     <= 16'h0;
         bwait_ff    <= 1'b0;
         dec_pend_ff <= 1'b0;
         if (nxt_st == MMC_BOOT)
            key_ff <= {fuse_mem[8], fuse_mem[9], fuse_mem[10], fuse_mem[11]};
      end else begin
         bwait_ff <= !boot_end;
         // one word in the decryptor at a time
         if (dec_in_valid)
            dec_pend_ff <= 1'b1;
         else if (dec_out_valid)
            dec_pend_ff <= 1'b0;
         if (word_in)
            bcnt_ff <= bcnt_ff + 16'h1;
      end
   end

   // ram: boot copy or cpu, byte lanes
   wire        ram_cpu_wr  = take && cpu_req.we && hit_ram;
   wire        ram_boot_wr = st_ff == MMC_BOOT && word_in;
   wire [31:0] ram_rd;
   for (genvar g = 0; g < 4; g++) begin : g_lane
      // one array per lane so each array has a single writer
      logic [7:0] lane_mem [`MMC_RAM_WORDS];
      always_ff @(posedge core_clk) begin
         if (ram_boot_wr)
            lane_mem[boot_idx] <= word_val[8*g +: 8];
         else if (ram_cpu_wr && cpu_req.be[g] && ram_pwr_en)
            lane_mem[ram_idx] <= cpu_req.wdata[8*g +: 8];
      end
      // ram lane read for the one cycle answer
      assign ram_rd[8*g +: 8] = lane_mem[ram_idx];
   end

   // otp: bits only set, user words only
   always_ff @(posedge core_clk) begin
      if (fuse_prog_req && !running && fuse_prog_idx >= 4'(`MMC_FUSE_KEY_LO)
          && fuse_prog_idx < 4'(`MMC_FUSE_WORDS))
         fuse_mem[fuse_prog_idx] <= fuse_mem[fuse_prog_idx] | fuse_prog_data;
   end

   // cpu response; memories answer next cycle
   wire [31:0] mem_rd = hit_ram  ? ram_rd :
                        hit_fuse ? fuse_mem[fuse_idx] : rom_rdata;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu_rsp  <= '0;
         lat_ff   <= 2'd0;
         peri_bus <= '0;
      end else begin
         cpu_rsp.ack <= 1'b0;
         cpu_rsp.err <= 1'b0;
         if (take && bad) begin
            cpu_rsp.err   <= 1'b1;
            cpu_rsp.rdata <= 32'h0;
         end else if (take && hit_peri) begin
            lat_ff   <= 2'(`MMC_PERI_LAT - 1);
            peri_bus <= '{sel: 1'b1, we: cpu_req.we, be: cpu_req.be,
                          addr: a[15:0], wdata: cpu_req.wdata};
         end else if (take) begin
            cpu_rsp.ack   <= 1'b1;
            cpu_rsp.rdata <= cpu_req.we ? 32'h0 : mem_rd;
         end else if (lat_ff != 2'd0) begin
            lat_ff <= lat_ff - 2'd1;
            if (lat_ff == 2'd1) begin
               cpu_rsp.ack   <= 1'b1;
               cpu_rsp.rdata <= peri_bus.we ? 32'h0 : peri_rdata;
               peri_bus      <= '0;
            end
         end
      end
   end

   // vectors for reset entry and bus error
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu_vec_valid <= 1'b0;
         cpu_vec       <= 32'h0;
      end else begin
         cpu_vec_valid <= 1'b0;
         if (st_ff == MMC_BOOT && nxt_st == MMC_RUN) begin
            cpu_vec_valid <= 1'b1;
            cpu_vec       <= `MMC_VEC_RESET;
         end else if (take && bad) begin
            cpu_vec_valid <= 1'b1;
            cpu_vec       <= `MMC_VEC_BUS_ERR;
         end
      end
   end

   // slow source choice, first strobe wins
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         slow_src_ff  <= 1'b0;
         slow_lock_ff <= 1'b0;
      end else if (sw_reset_req) begin
         // back to rc on any reset
         slow_src_ff  <= 1'b0;
         slow_lock_ff <= 1'b0;
      end else if (slow_sel_strobe && !slow_lock_ff && running) begin
         slow_src_ff  <= slow_sel_ext;
         slow_lock_ff <= 1'b1;
      end
   end

   // fast cycles over CAL_TICKS slow periods
   logic        slow_d_ff;
   logic        cal_run_ff;
   logic [7:0]  tick_ff;
   wire         slow_rise = slow_clock && !slow_d_ff;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         slow_d_ff  <= 1'b0;
         cal_run_ff <= 1'b0;
         tick_ff    <= 8'h0;
         cal_count  <= 32'h0;
         cal_done   <= 1'b0;
      end else begin
         slow_d_ff <= slow_clock;
         if (cal_start && !cal_run_ff) begin
            cal_run_ff <= 1'b1;
            cal_done   <= 1'b0;
            tick_ff    <= 8'h0;
            cal_count  <= 32'h0;
         end else if (cal_run_ff) begin
            cal_count <= cal_count + 32'h1;
            if (slow_rise) begin
               tick_ff <= tick_ff + 8'h1;
               if (tick_ff == 8'(CAL_TICKS - 1)) begin
                  cal_run_ff <= 1'b0;
                  cal_done   <= 1'b1;
               end
            end
         end
      end
   end
endmodule : mmc_ctrl

// *** mmc_ctrl_props.sv ***
// assertions on the ports of the memory map and reset controller
`timescale 1ns/1ps
`include "mmc_cfg.svh"
module mmc_ctrl_props (
   // clock and reset
   input wire logic                  core_clk,
   input wire logic                  rst_b,
   // cpu side
   input wire mmc_pkg::mmc_cpu_req_s cpu_req,
   input wire logic                  cpu_ready,
   input wire mmc_pkg::mmc_cpu_rsp_s cpu_rsp,
   input wire logic                  cpu_vec_valid,
   input wire logic [31:0]           cpu_vec,
   // power, reset and slow clock
   input wire logic                  boot_flash_select_b,
   input wire logic                  ram_retain,
   input wire logic                  ram_pwr_en,
   input wire logic                  xtal_en,
   input wire logic                  sys_rst_b,
   input wire logic                  slow_src_ext
);
   import mmc_pkg::*;
   wire logic [31:0] a      = cpu_req.addr;
   wire logic        take   = cpu_req.req && cpu_ready;
   wire logic        in_rom = a < `MMC_ROM_BYTES;
   wire logic        in_ram = a >= `MMC_RAM_BASE && a < `MMC_RAM_BASE + `MMC_RAM_BYTES;
   wire logic        in_fus = a >= `MMC_FUSE_BASE && a < `MMC_FUSE_BASE + `MMC_FUSE_BYTES;
   wire logic        in_per = a >= `MMC_PERI_BASE && a < `MMC_PERI_BASE + `MMC_PERI_BYTES;
   wire logic        mem_rd = take && !cpu_req.we && (in_rom || in_ram);
   wire logic        bad    = take && !(in_rom || in_ram || in_fus || in_per);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // peripheral access holds the bus for two cycles, answers on the third
   sequence peri_wait;
      !cpu_ready [*2] ##1 (cpu_rsp.ack && cpu_ready);
   endsequence
   sequence err_vec;
      cpu_rsp.err && cpu_vec_valid && cpu_vec == `MMC_VEC_BUS_ERR;
   endsequence
   chk_mem_one_cycle: assert property (mem_rd |=> cpu_rsp.ack && !cpu_rsp.err)
      else $error("memory read not answered in one cycle");
   chk_peri_three: assert property (take && in_per |=> peri_wait)
      else $error("peripheral access not three cycles");
   chk_bad_err: assert property (bad |=> err_vec)
      else $error("unmapped access without bus error vector");
   chk_err_no_data: assert property (cpu_rsp.err |-> cpu_rsp.rdata == 32'h0)
      else $error("bus error carries data");
   chk_reset_vec: assert property (cpu_vec_valid && !cpu_rsp.err |-> cpu_vec == `MMC_VEC_RESET)
      else $error("start vector wrong");
   chk_xtal_first: assert property (!xtal_en |-> !sys_rst_b && boot_flash_select_b)
      else $error("logic runs before crystal");
   chk_sel_boot: assert property (!boot_flash_select_b |-> !sys_rst_b)
      else $error("flash select outside boot copy");
   chk_ram_retain: assert property (ram_retain |-> ram_pwr_en)
      else $error("ram power lost while retained");
   chk_slow_lock: assert property ($fell(slow_src_ext) |-> !sys_rst_b)
      else $error("slow source changed while running");
   chk_release_ready: assert property ($rose(sys_rst_b) |-> xtal_en && cpu_ready)
      else $error("release without crystal or cpu");
endmodule : mmc_ctrl_props
bind mmc_ctrl mmc_ctrl_props u_props (.core_clk, .rst_b, .cpu_req, .cpu_ready, .cpu_rsp,
   .cpu_vec_valid, .cpu_vec, .boot_flash_select_b, .ram_retain, .ram_pwr_en, .xtal_en,
   .sys_rst_b, .slow_src_ext);

// *** mmc_far_model.sv ***
// far side model: rom macro, peripheral registers, boot flash and decryptor
`timescale 1ns/1ps
module mmc_far_model (
   // clock
   input wire logic               core_clk,
   // rom and peripherals
   input wire logic [15:0]        rom_addr,
   output logic [31:0]            rom_rdata,
   input wire mmc_pkg::mmc_peri_s peri_bus,
   output logic [31:0]            peri_rdata,
   // boot flash
   input wire logic               boot_flash_select_b,
   input wire logic               flash_req,
   input wire logic [15:0]        flash_addr,
   output logic                   flash_valid,
   output logic [31:0]            flash_data,
   // decryptor, pass-through so plain and encrypted boots give the same words
   input wire logic               dec_in_valid,
   input wire logic [31:0]        dec_in_data,
   output logic                   dec_out_valid,
   output logic [31:0]            dec_out_data
);
   import mmc_pkg::*;
   logic [15:0] tick_ff = 16'h0;
   wire logic   give    = flash_req && !boot_flash_select_b && !flash_valid && tick_ff[0];
   assign rom_rdata = {rom_addr, ~rom_addr};
   // unselected bus shows a changing pattern, never the last answer
   assign peri_rdata = peri_bus.sel ? 32'hbeef_1234 : {tick_ff, ~tick_ff};
   // words only while selected, at most every other cycle
   always_ff @(posedge core_clk) begin
      tick_ff       <= tick_ff + 16'h1;
      flash_valid   <= give;
      flash_data    <= give ? {16'hf1a5, flash_addr} : {tick_ff, tick_ff};
      dec_out_valid <= dec_in_valid;
      dec_out_data  <= dec_in_data;
   end
endmodule : mmc_far_model

// *** memory_map_clock_reset_ctrl_tb.sv ***
// self-checking bench for the memory map and reset controller
`timescale 1ns/1ps
`include "mmc_cfg.svh"
module memory_map_clock_reset_ctrl_tb;
   import mmc_pkg::*;
   logic core_clk = 1'b0, rst_b = 1'b0, sw_reset_req = 1'b0, ram_retain = 1'b0;
   logic slow_sel_strobe = 1'b0, slow_sel_ext = 1'b0, slow_rc_clock = 1'b0;
   logic cal_start = 1'b0, slow_ref_clock_input = 1'b0, boot_enc_en = 1'b0, fuse_prog_req = 1'b0;
   logic [3:0]   fuse_prog_idx = 4'h0;
   logic [31:0]  fuse_prog_data = 32'h0;
   mmc_cpu_req_s cpu_req = '0;
   mmc_cpu_rsp_s cpu_rsp;
   mmc_peri_s    peri_bus;
   logic cpu_ready, cpu_vec_valid, boot_flash_select_b, flash_req, flash_valid, dec_in_valid;
   logic dec_out_valid, ram_pwr_en, rc_osc_en, xtal_en, logic_pwr_en, sys_rst_b;
   logic slow_src_ext, slow_clock, cal_done;
   logic [15:0]  rom_addr, flash_addr;
   logic [31:0]  cpu_vec, rom_rdata, peri_rdata, flash_data, dec_in_data, dec_out_data, cal_count;
   logic [127:0] dec_key;
   int err_total = 0, checks_done = 0;
   always #4 core_clk = ~core_clk;
   always #8 slow_rc_clock = ~slow_rc_clock;
   always #16 slow_ref_clock_input = ~slow_ref_clock_input;
   mmc_ctrl #(.RC_CYC(8), .XTAL_CYC(8)) uut (.core_clk, .rst_b, .sw_reset_req, .cpu_req,
      .cpu_ready, .cpu_rsp, .cpu_vec_valid, .cpu_vec, .rom_addr, .rom_rdata, .peri_bus,
      .peri_rdata, .fuse_prog_req, .fuse_prog_idx, .fuse_prog_data,
      .boot_enc_en, .boot_word_cnt(16'h4), .boot_flash_select_b, .flash_req,
      .flash_addr, .flash_valid, .flash_data, .dec_key, .dec_in_valid, .dec_in_data,
      .dec_out_valid, .dec_out_data, .ram_retain, .ram_pwr_en, .rc_osc_en, .xtal_en,
      .logic_pwr_en, .sys_rst_b, .slow_sel_strobe, .slow_sel_ext, .slow_rc_clock,
      .slow_ref_clock_input, .slow_src_ext, .slow_clock, .cal_start, .cal_done, .cal_count);
   mmc_far_model far (.core_clk, .rom_addr, .rom_rdata, .peri_bus, .peri_rdata,
      .boot_flash_select_b, .flash_req, .flash_addr, .flash_valid, .flash_data,
      .dec_in_valid, .dec_in_data, .dec_out_valid, .dec_out_data);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   // one cpu transfer; lat counts edges from take to answer
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r, output int lat);
      int n;
      n = 0;
      cyc(1);
      cpu_req = '{req: 1'b1, we: w, be: 4'hf, addr: a, wdata: d};
      while (cpu_ready !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      cyc(1);
      cpu_req.req = 1'b0;
      lat = 1;
      while (!(cpu_rsp.ack || cpu_rsp.err) && lat < 8) begin
         cyc(1);
         lat++;
      end
      r = cpu_rsp.rdata;
   endtask : bus
   task automatic t_power_up();
      int n;
      n = 0;
      chk(32'(xtal_en), 32'h0);
      chk(32'(sys_rst_b), 32'h0);
      chk(32'(rc_osc_en && !logic_pwr_en), 32'h1);
      while (cpu_vec_valid !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      chk(cpu_vec, `MMC_VEC_RESET);
      chk(32'(n >= 12 && xtal_en), 32'h1);
      chk(32'(logic_pwr_en), 32'h1);
   endtask : t_power_up
   // programs while the sequencer waits; word 3 is not a user word
   task automatic t_fuse();
      logic [3:0] idx [5] = '{4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
      fuse_prog_data = 32'hffff_ffff;
      foreach (idx[i]) begin
         fuse_prog_req = 1'b1;
         fuse_prog_idx = idx[i];
         cyc(1);
      end
      fuse_prog_req = 1'b0;
   endtask : t_fuse
   task automatic t_boot();
      logic [31:0] r;
      int lat;
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, `MMC_RAM_BASE + 32'(4 * i), 32'h0, r, lat);
         chk(r, {16'hf1a5, 16'(i)});
      end
   endtask : t_boot
   task automatic t_mem();
      logic [31:0] r;
      int lat;
      ram_retain = 1'b1;
      bus(1'b0, 32'h0002_fffc, 32'h0, r, lat);
      chk(r, 32'hbfff_4000);
      chk(32'(lat), 32'h1);
      bus(1'b1, 32'h0401_7ffc, 32'h5a5a_c3c3, r, lat);
      bus(1'b0, 32'h0401_7ffc, 32'h0, r, lat);
      chk(r, 32'h5a5a_c3c3);
      chk(32'(lat), 32'h1);
      bus(1'b0, `MMC_FUSE_BASE + 32'h20, 32'h0, r, lat);
      chk(r, 32'hffff_ffff);
      bus(1'b0, `MMC_FUSE_BASE + 32'h2c, 32'h0, r, lat);
      chk(r, 32'hffff_ffff);
      bus(1'b0, `MMC_FUSE_BASE + 32'h0c, 32'h0, r, lat);
      chk(32'(r === 32'hffff_ffff), 32'h0);
      chk(32'(dec_key == {4{32'hffff_ffff}}), 32'h1);
      ram_retain = 1'b0;
      bus(1'b0, 32'h0200_0010, 32'h0, r, lat);
      chk(r, 32'hbeef_1234);
      chk(32'(lat), 32'h3);
   endtask : t_mem
   task automatic t_bad();
      logic [31:0] bad_a [4] = '{32'h0003_0000, 32'h0100_0030, 32'h0201_0000, 32'h0401_8000};
      logic [31:0] r;
      int lat;
      foreach (bad_a[i]) begin
         bus(1'b0, bad_a[i], 32'h0, r, lat);
         chk(32'(cpu_rsp.err), 32'h1);
         chk(cpu_vec, `MMC_VEC_BUS_ERR);
         chk(r, 32'h0);
      end
      // a wrapped decode would land on word zero
      bus(1'b1, 32'h0401_8000, 32'hffff_ffff, r, lat);
      chk(32'(cpu_rsp.err), 32'h1);
      bus(1'b0, `MMC_RAM_BASE, 32'h0, r, lat);
      chk(r, 32'hf1a5_0000);
   endtask : t_bad
   task automatic t_slow();
      int n;
      n = 0;
      cal_start = 1'b1;
      cyc(1);
      cal_start = 1'b0;
      while (cal_done !== 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
      // rc period is two core cycles, eight edges counted
      chk(32'(cal_count >= 14 && cal_count <= 18), 32'h1);
      slow_sel_ext = 1'b1;
      slow_sel_strobe = 1'b1;
      cyc(1);
      slow_sel_ext = 1'b0;
      cyc(1);
      slow_sel_strobe = 1'b0;
      cyc(1);
      chk(32'(slow_src_ext), 32'h1);
      chk(32'(slow_clock), 32'(slow_ref_clock_input));
      // next boot runs through the decryptor
      boot_enc_en = 1'b1;
      sw_reset_req = 1'b1;
      cyc(1);
      sw_reset_req = 1'b0;
      ram_retain = 1'b1;
      chk(32'(slow_src_ext), 32'h0);
      cyc(1);
      chk(32'(ram_pwr_en), 32'h1);
      ram_retain = 1'b0;
      cyc(1);
      chk(32'(ram_pwr_en), 32'h0);
      t_power_up();
      chk(32'(slow_clock), 32'(slow_rc_clock));
   endtask : t_slow
   initial begin
      cyc(4);
      rst_b = 1'b1;
      t_fuse();
      t_power_up();
      t_boot();
      t_mem();
      t_bad();
      t_slow();
      t_boot();
      end_sim();
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      err_total++;
      $display("mismatch at %0t: run did not finish", $time);
      end_sim();
   end
endmodule : memory_map_clock_reset_ctrl_tb
